/* src/cspr_defs.vh */
// Register map, field positions, reset values and timing counts for clock control
`ifndef CSPR_DEFS_VH
`define CSPR_DEFS_VH
// Register byte addresses
`define CSPR_ADDR_TRIM_HIGH 4'h0
`define CSPR_ADDR_TRIM_LOW 4'h4
`define CSPR_ADDR_STATUS 4'h8
`define CSPR_ADDR_PRESET_5V 4'hC
// Reset values of the trim registers
`define CSPR_TRIM_HIGH_RST 8'hFF
`define CSPR_TRIM_LOW_RST 2'h3
// Status register fields
`define CSPR_STAT_LOCKED 0
`define CSPR_STAT_CLK_OUT_EN 1
`define CSPR_STAT_HALVER 2
`define CSPR_STAT_PRESET_SEL 7
// Option bit layout: [0] PLL enable, [1] ratio x8, [2] high supply range
`define CSPR_OPT_PLL_EN 0
`define CSPR_OPT_X8 1
`define CSPR_OPT_HIGHV 2
// Clock source codes
`define CSPR_SRC_EXT 2'h0
`define CSPR_SRC_XTAL 2'h1
`define CSPR_SRC_RC 2'h2
// Trim midpoint used by a halving search
`define CSPR_TRIM_MID 10'h200
// PLL startup delay and lock time, in ns, and derived cycles at 20 ns
`define CSPR_CLK_NS 20
`define CSPR_STARTUP_NS 2000
`define CSPR_LOCK_NS 4000
`define CSPR_STARTUP_CYC ((`CSPR_STARTUP_NS + `CSPR_CLK_NS - 1) / `CSPR_CLK_NS)
`define CSPR_LOCK_CYC ((`CSPR_LOCK_NS + `CSPR_CLK_NS - 1) / `CSPR_CLK_NS)
`endif

/* src/cspr_preset_rom.v */
// Factory trim preset store: two 10-bit presets, erasable on protection removal
`timescale 1ns/100ps
`default_nettype none
module cspr_preset_rom (
    input wire clk_in,
    input wire rst_in,
    input wire erase_in,
    input wire sel_3v_in,
    output reg [9:0] data_out
);
    parameter [9:0] PRESET_5V = 10'h200;
    parameter [9:0] PRESET_3V = 10'h200;

    reg erased;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            erased <= 1'b0;
        end else if (erase_in) begin
            erased <= 1'b1;
        end
    end

    // Read data registered; erased flash reads as all ones
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= 10'h3FF;
        end else if (erased || erase_in) begin
            data_out <= 10'h3FF;
        end else begin
            data_out <= sel_3v_in ? PRESET_3V : PRESET_5V;
        end
    end
endmodule
`default_nettype wire

/* src/cspr_clock_ctrl.v */
// Clock source, PLL control and RC trim block with AXI4-Lite registers
// How it works
// RULE1 - Enabled PLL multiplies 1 MHz RC or external input by four or eight
// RULE2 - PLL enable and ratio come from three option bits, not software
// RULE3 - x4 target at high supply runs x8 with halver; else halver off
// RULE4 - After reset or halt wakeup, output clock withheld for startup delay; code enables it the first cycle after reset, withholds it only with PLL on
// RULE5 - Lock flag in status register set when PLL reaches frequency
// RULE6 - Option byte picks external clock, one of four crystals, or RC
// RULE7 - Crystal oscillator keeps running during reset
// RULE8 - Every reset returns trim to high FFh, low 03h
// RULE9 - High trim register holds trim bits 9:2, read/write, resets FFh
// RULE10 - Low trim holds bits 1:0, resets 03h; software keeps upper bits zero
// RULE11 - Larger trim value gives lower RC frequency; zero gives highest
// RULE12 - Software writes trim to both registers straight after each reset
// RULE13 - Two factory trim presets, for 5 V and 3 V supply
// RULE14 - Both presets erased when read-out protection is removed after set
// RULE15 - Software tunes trim by halving search starting at midpoint
// RULE16 - Software calibrates RC-driven PLL clock through trim registers
// RULE17 - Trim presented as one 10-bit value, each write applied at once
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cspr_defs.vh"
module cspr_clock_ctrl (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RST_IN,
    // Option bits
    input wire [2:0] PLL_OPT_IN,
    input wire [1:0] CLK_SRC_OPT_IN,
    input wire [1:0] XTAL_RANGE_IN,
    input wire PROT_REMOVED_IN,
    input wire HALT_WAKEUP_IN,
    // Analog oscillator control
    output reg [9:0] RC_TRIM_VALUE_OUT,
    output reg XTAL_RUN_OUT,
    output reg [1:0] XTAL_RANGE_OUT,
    output reg RC_EN_OUT,
    output reg EXT_SEL_OUT,
    output reg PLL_EN_OUT,
    output reg PLL_X8_OUT,
    output reg HALVER_OUT,
    output reg CLK_OUT_EN_OUT,
    output reg PLL_LOCKED_OUT,
    // AXI4-Lite write address
    input wire [3:0] AWADDR_IN,
    input wire AWVALID_IN,
    output wire AWREADY_OUT,
    // AXI4-Lite write data
    input wire [31:0] WDATA_IN,
    input wire [3:0] WSTRB_IN,
    input wire WVALID_IN,
    output wire WREADY_OUT,
    // AXI4-Lite write response
    output reg [1:0] BRESP_OUT,
    output reg BVALID_OUT,
    input wire BREADY_IN,
    // AXI4-Lite read address
    input wire [3:0] ARADDR_IN,
    input wire ARVALID_IN,
    output wire ARREADY_OUT,
    // AXI4-Lite read data
    output reg [31:0] RDATA_OUT,
    output reg [1:0] RRESP_OUT,
    output reg RVALID_OUT,
    input wire RREADY_IN
);
    localparam [1:0] PLL_IDLE = 2'h0;
    localparam [1:0] PLL_START = 2'h1;
    localparam [1:0] PLL_LOCK = 2'h2;
    localparam [1:0] PLL_RUN = 2'h3;
    // Counts are worked out 32 bits wide, then cut to the counter width on purpose
    localparam [31:0] STARTUP_FULL = `CSPR_STARTUP_CYC;
    localparam [31:0] LOCK_FULL = `CSPR_LOCK_CYC;
    localparam [7:0] STARTUP_CYC = STARTUP_FULL[7:0];
    localparam [7:0] LOCK_CYC = LOCK_FULL[7:0];

    reg [7:0] trim_upper_bits;
    reg [1:0] trim_lower_bits;
    reg [1:0] pll_state;
    reg [1:0] next_pll_state;
    reg [7:0] pll_count;
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [7:0] w_byte;
    reg w_lane0;
    reg preset_sel;
    wire [9:0] preset_data;
    wire pll_on;
    wire wr_fire;
    reg [31:0] status_word;

    // Preset store
    // RULE13 presets held
    cspr_preset_rom u_rom (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        // RULE14 erase on unprotect
        .erase_in(PROT_REMOVED_IN),
        .sel_3v_in(preset_sel),
        .data_out(preset_data)
    );

    // RULE2 option bits select
    assign pll_on = PLL_OPT_IN[`CSPR_OPT_PLL_EN];

    // Source selection and PLL ratio; held registered so outputs are glitch free
    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            // RULE7 crystal runs in reset
            XTAL_RUN_OUT <= 1'b1;
            XTAL_RANGE_OUT <= 2'h0;
            RC_EN_OUT <= 1'b0;
            EXT_SEL_OUT <= 1'b0;
            PLL_EN_OUT <= 1'b0;
            PLL_X8_OUT <= 1'b0;
            HALVER_OUT <= 1'b0;
        end else begin
            // RULE6 source by option
            XTAL_RUN_OUT <= (CLK_SRC_OPT_IN == `CSPR_SRC_XTAL);
            XTAL_RANGE_OUT <= XTAL_RANGE_IN;
            RC_EN_OUT <= (CLK_SRC_OPT_IN == `CSPR_SRC_RC);
            EXT_SEL_OUT <= (CLK_SRC_OPT_IN == `CSPR_SRC_EXT);
            // RULE1 PLL on 1 MHz source, never on a crystal
            PLL_EN_OUT <= pll_on && (CLK_SRC_OPT_IN != `CSPR_SRC_XTAL);
            // RULE3 x4 at high supply uses x8 and halver
            if (!PLL_OPT_IN[`CSPR_OPT_X8] && PLL_OPT_IN[`CSPR_OPT_HIGHV]) begin
                PLL_X8_OUT <= 1'b1;
                HALVER_OUT <= pll_on;
            end else begin
                PLL_X8_OUT <= PLL_OPT_IN[`CSPR_OPT_X8];
                HALVER_OUT <= 1'b0;
            end
        end
    end

    // PLL startup sequencing
    always @* begin
        next_pll_state = pll_state;
        case (pll_state)
            PLL_IDLE: begin
                if (PLL_EN_OUT) begin
                    next_pll_state = PLL_START;
                end
            end
            PLL_START: begin
                if (pll_count == STARTUP_CYC - 8'h01) begin
                    next_pll_state = PLL_LOCK;
                end
            end
            PLL_LOCK: begin
                if (pll_count == LOCK_CYC - 8'h01) begin
                    next_pll_state = PLL_RUN;
                end
            end
            PLL_RUN: begin
                next_pll_state = PLL_RUN;
            end
            default: begin
                next_pll_state = PLL_IDLE;
            end
        endcase
        // RULE4 restart after halt wakeup
        if (HALT_WAKEUP_IN || !PLL_EN_OUT) begin
            next_pll_state = PLL_IDLE;
        end
    end

    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pll_state <= PLL_IDLE;
            pll_count <= 8'h00;
            CLK_OUT_EN_OUT <= 1'b0;
            PLL_LOCKED_OUT <= 1'b0;
        end else begin
            pll_state <= next_pll_state;
            if (next_pll_state != pll_state) begin
                pll_count <= 8'h00;
            end else begin
                pll_count <= pll_count + 8'h01;
            end
            // RULE4 clock withheld until delay
            CLK_OUT_EN_OUT <= !PLL_EN_OUT ? 1'b1 :
                (next_pll_state == PLL_LOCK || next_pll_state == PLL_RUN);
            // RULE5 lock flag set
            PLL_LOCKED_OUT <= (next_pll_state == PLL_RUN);
        end
    end

    // AXI4-Lite write path: address and data latched in either order
    assign AWREADY_OUT = !aw_held && !BVALID_OUT;
    assign WREADY_OUT = !w_held && !BVALID_OUT;
    assign wr_fire = aw_held && w_held && !BVALID_OUT;

    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= 2'h0;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR_IN;
            end
            if (WVALID_IN && WREADY_OUT) begin
                w_held <= 1'b1;
                w_byte <= WDATA_IN[7:0];
                w_lane0 <= WSTRB_IN[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                BVALID_OUT <= 1'b1;
                // Unmapped or read-only offsets answer SLVERR
                BRESP_OUT <= (aw_addr == `CSPR_ADDR_TRIM_HIGH ||
                    aw_addr == `CSPR_ADDR_TRIM_LOW ||
                    aw_addr == `CSPR_ADDR_STATUS) ? 2'h0 : 2'h2;
            end else if (BVALID_OUT && BREADY_IN) begin
                BVALID_OUT <= 1'b0;
            end
        end
    end

    // Trim registers
    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            // RULE8 trim defaults on reset
            trim_upper_bits <= `CSPR_TRIM_HIGH_RST;
            trim_lower_bits <= `CSPR_TRIM_LOW_RST;
            preset_sel <= 1'b0;
        end else if (wr_fire && w_lane0) begin
            // RULE9 high register writable
            if (aw_addr == `CSPR_ADDR_TRIM_HIGH) begin
                trim_upper_bits <= w_byte;
            end
            // RULE10 only two low bits stored
            if (aw_addr == `CSPR_ADDR_TRIM_LOW) begin
                trim_lower_bits <= w_byte[1:0];
            end
            // Status write picks which preset the preset word shows
            if (aw_addr == `CSPR_ADDR_STATUS) begin
                preset_sel <= w_byte[`CSPR_STAT_PRESET_SEL];
            end
        end
    end

    // RULE17 combined value applied at once
    // RULE11 larger code, lower frequency
    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RC_TRIM_VALUE_OUT <= {`CSPR_TRIM_HIGH_RST, `CSPR_TRIM_LOW_RST};
        end else begin
            RC_TRIM_VALUE_OUT <= {trim_upper_bits, trim_lower_bits};
        end
    end

    // AXI4-Lite read path
    assign ARREADY_OUT = !RVALID_OUT;
    // Status word built from the field positions so the map lives in one place
    always @* begin
        status_word = 32'h00000000;
        status_word[`CSPR_STAT_LOCKED] = PLL_LOCKED_OUT;
        status_word[`CSPR_STAT_CLK_OUT_EN] = CLK_OUT_EN_OUT;
        status_word[`CSPR_STAT_HALVER] = HALVER_OUT;
        status_word[`CSPR_STAT_PRESET_SEL] = preset_sel;
    end

    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h00000000;
            RRESP_OUT <= 2'h0;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RRESP_OUT <= 2'h0;
            case (ARADDR_IN)
                `CSPR_ADDR_TRIM_HIGH: begin
                    RDATA_OUT <= {24'h000000, trim_upper_bits};
                end
                `CSPR_ADDR_TRIM_LOW: begin
                    RDATA_OUT <= {30'h00000000, trim_lower_bits};
                end
                `CSPR_ADDR_STATUS: begin
                    RDATA_OUT <= status_word;
                end
                `CSPR_ADDR_PRESET_5V: begin
                    RDATA_OUT <= {22'h000000, preset_data};
                end
                default: begin
                    RDATA_OUT <= 32'h00000000;
                    RRESP_OUT <= 2'h2;
                end
            endcase
        end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* test/cspr_clock_ctrl_sva.sv */
// Checker of option decode, reset values and PLL timing
`timescale 1ns/100ps
`default_nettype none
module cspr_chk (
    // Clock, reset, options
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic [2:0] PLL_OPT_IN,
    input wire logic [1:0] CLK_SRC_OPT_IN,
    input wire logic HALT_WAKEUP_IN,
    // Clock control
    input wire logic [9:0] RC_TRIM_VALUE_OUT,
    input wire logic XTAL_RUN_OUT,
    input wire logic RC_EN_OUT,
    input wire logic PLL_EN_OUT,
    input wire logic PLL_X8_OUT,
    input wire logic HALVER_OUT,
    input wire logic CLK_OUT_EN_OUT,
    input wire logic PLL_LOCKED_OUT
);
    logic [4:0] po;
    logic pr;
    int hold;
    int run;
    // Decodes are registered, so compare only once options held for an edge
    wire q = !pr && po == {CLK_SRC_OPT_IN, PLL_OPT_IN};
    always @(posedge REF_CLK_IN) begin
        po <= {CLK_SRC_OPT_IN, PLL_OPT_IN};
        pr <= RST_IN;
    end
    always @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hold <= 0;
            run <= 0;
        end else begin
            hold <= PLL_EN_OUT && !CLK_OUT_EN_OUT ? hold + 1 : 0;
            run <= PLL_EN_OUT && CLK_OUT_EN_OUT ? run + 1 : 0;
        end
    end
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    x8_sel_a: assert property (q |-> PLL_X8_OUT == (PLL_OPT_IN[1] | PLL_OPT_IN[2]))
        else $error("ratio wrong");
    halver_sel_a: assert property (q |-> HALVER_OUT == (PLL_OPT_IN == 3'h5))
        else $error("halver wrong");
    pll_en_a: assert property (q |->
        PLL_EN_OUT == (PLL_OPT_IN[0] && CLK_SRC_OPT_IN != 2'h1)) else $error("pll enable wrong");
    src_sel_a: assert property (q |-> RC_EN_OUT == (CLK_SRC_OPT_IN == 2'h2))
        else $error("source wrong");
    xtal_rst_a: assert property (disable iff (1'b0) RST_IN |-> XTAL_RUN_OUT)
        else $error("crystal stopped in reset");
    trim_rst_a: assert property ($fell(RST_IN) |-> RC_TRIM_VALUE_OUT == 10'h3FF)
        else $error("trim not default");
    startup_a: assert property (
        $rose(CLK_OUT_EN_OUT) && PLL_EN_OUT |-> hold > 96 && hold < 104) else $error("startup");
    lock_a: assert property ($rose(PLL_LOCKED_OUT) |-> run > 196 && run < 204)
        else $error("lock time");
    wake_a: assert property (HALT_WAKEUP_IN && PLL_EN_OUT |-> ##[1:3] !CLK_OUT_EN_OUT)
        else $error("wakeup clock");
    lock_c: cover property ($rose(PLL_LOCKED_OUT));
    halver_c: cover property (HALVER_OUT && PLL_LOCKED_OUT);
    wake_c: cover property (HALT_WAKEUP_IN && PLL_LOCKED_OUT);
endmodule
bind cspr_clock_ctrl cspr_chk u_chk (.REF_CLK_IN, .RST_IN, .PLL_OPT_IN, .CLK_SRC_OPT_IN,
    .HALT_WAKEUP_IN, .RC_TRIM_VALUE_OUT, .XTAL_RUN_OUT, .RC_EN_OUT, .PLL_EN_OUT,
    .PLL_X8_OUT, .HALVER_OUT, .CLK_OUT_EN_OUT, .PLL_LOCKED_OUT);
`default_nettype wire

/* test/tb.sv */
// Bench: register bus, option decode and PLL timing
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic REF_CLK_IN = 1'b0, RST_IN = 1'b0, PROT_REMOVED_IN = 1'b0, HALT_WAKEUP_IN = 1'b0;
    logic [2:0] PLL_OPT_IN = 3'h0;
    logic [1:0] CLK_SRC_OPT_IN = 2'h2, XTAL_RANGE_IN = 2'h1;
    logic [3:0] AWADDR_IN = 4'h0, ARADDR_IN = 4'h0, WSTRB_IN = 4'hF;
    logic [31:0] WDATA_IN = 32'h0;
    logic AWVALID_IN = 1'b0, WVALID_IN = 1'b0, BREADY_IN = 1'b0;
    logic ARVALID_IN = 1'b0, RREADY_IN = 1'b0;
    logic [9:0] RC_TRIM_VALUE_OUT;
    logic [1:0] XTAL_RANGE_OUT, BRESP_OUT, RRESP_OUT;
    logic XTAL_RUN_OUT, RC_EN_OUT, EXT_SEL_OUT, PLL_EN_OUT, PLL_X8_OUT, HALVER_OUT;
    logic CLK_OUT_EN_OUT, PLL_LOCKED_OUT, AWREADY_OUT, WREADY_OUT, BVALID_OUT;
    logic ARREADY_OUT, RVALID_OUT;
    logic [31:0] RDATA_OUT;
    logic [2:0] opt_t [3] = '{3'h1, 3'h5, 3'h3};
    int fail_count = 0;
    int check_count = 0;
    logic [9:0] tv, ts;
    cspr_clock_ctrl DUT (.REF_CLK_IN, .RST_IN, .PLL_OPT_IN, .CLK_SRC_OPT_IN, .XTAL_RANGE_IN,
        .PROT_REMOVED_IN, .HALT_WAKEUP_IN, .RC_TRIM_VALUE_OUT, .XTAL_RUN_OUT, .XTAL_RANGE_OUT,
        .RC_EN_OUT, .EXT_SEL_OUT, .PLL_EN_OUT, .PLL_X8_OUT, .HALVER_OUT, .CLK_OUT_EN_OUT,
        .PLL_LOCKED_OUT, .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT, .WDATA_IN, .WSTRB_IN,
        .WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN,
        .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN);
    always #10 REF_CLK_IN = ~REF_CLK_IN;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic lim(input int n);
        if (n >= 400) begin
            fail_count++;
            end_of_test;
        end
    endtask
    // One access; handshakes sampled at the falling edge, acted on at the next rising one
    task automatic acc(input bit w, input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        logic ah, wh, rh, h;
        logic [1:0] r;
        logic [31:0] v;
        n = 0;
        h = 0;
        @(posedge REF_CLK_IN);
        if (w) begin
            AWADDR_IN <= a;
            WDATA_IN <= d;
            AWVALID_IN <= 1'b1;
            WVALID_IN <= 1'b1;
            BREADY_IN <= 1'b1;
        end else begin
            ARADDR_IN <= a;
            ARVALID_IN <= 1'b1;
            RREADY_IN <= 1'b1;
        end
        while (!h && n < 400) begin
            @(negedge REF_CLK_IN);
            ah = AWVALID_IN && AWREADY_OUT;
            wh = WVALID_IN && WREADY_OUT;
            rh = ARVALID_IN && ARREADY_OUT;
            h = w ? BVALID_OUT : RVALID_OUT;
            r = w ? BRESP_OUT : RRESP_OUT;
            v = RDATA_OUT;
            @(posedge REF_CLK_IN);
            if (ah)
                AWVALID_IN <= 1'b0;
            if (wh)
                WVALID_IN <= 1'b0;
            if (rh)
                ARVALID_IN <= 1'b0;
            n++;
        end
        BREADY_IN <= 1'b0;
        RREADY_IN <= 1'b0;
        lim(n);
        chk("resp", 32'(r), 32'(er));
        if (!w)
            chk($sformatf("reg %h", a), v, d);
    endtask
    // Startup then lock phase, counted in cycles
    task automatic pll_run;
        int n;
        repeat (3) @(negedge REF_CLK_IN);
        chk("withheld", 32'(CLK_OUT_EN_OUT), 0);
        n = 0;
        do begin
            @(negedge REF_CLK_IN);
            n++;
        end while (!CLK_OUT_EN_OUT && n < 400);
        lim(n);
        chk("startup", 32'(n > 94 && n < 104), 1);
        n = 0;
        do begin
            @(negedge REF_CLK_IN);
            n++;
        end while (!PLL_LOCKED_OUT && n < 400);
        lim(n);
        chk("lock", 32'(n > 195 && n < 205), 1);
    endtask
    task automatic rst;
        RST_IN <= 1'b1;
        repeat (5) @(posedge REF_CLK_IN);
        chk("xtal run", 32'(XTAL_RUN_OUT), 1);
        RST_IN <= 1'b0;
    endtask
    initial begin
        rst;
        chk("trim", 32'(RC_TRIM_VALUE_OUT), 32'h3FF);
        acc(1'b0, 4'h0, 32'hFF, 2'h0);
        acc(1'b0, 4'h4, 32'h3, 2'h0);
        acc(1'b1, 4'h0, 32'h5A, 2'h0);
        acc(1'b1, 4'h4, 32'h2, 2'h0);
        acc(1'b1, 4'hC, 32'h0, 2'h2);
        acc(1'b0, 4'h0, 32'h5A, 2'h0);
        acc(1'b0, 4'h4, 32'h2, 2'h0);
        chk("trim", 32'(RC_TRIM_VALUE_OUT), 32'h16A);
        acc(1'b0, 4'hC, 32'h200, 2'h0);
        acc(1'b1, 4'h8, 32'h80, 2'h0);
        PROT_REMOVED_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        PROT_REMOVED_IN <= 1'b0;
        acc(1'b0, 4'hC, 32'h3FF, 2'h0);
        acc(1'b0, 4'h8, 32'h82, 2'h0);
        rst;
        acc(1'b0, 4'h0, 32'hFF, 2'h0);
        acc(1'b0, 4'h4, 32'h3, 2'h0);
        acc(1'b1, 4'h0, 32'h5A, 2'h0);
        acc(1'b1, 4'h4, 32'h2, 2'h0);
        @(negedge REF_CLK_IN);
        chk("trim reload", 32'(RC_TRIM_VALUE_OUT), 32'h16A);
        $display("registers done");
        for (int s = 0; s < 3; s++) begin
            CLK_SRC_OPT_IN <= 2'(s);
            XTAL_RANGE_IN <= 2'(3 - s);
            PLL_OPT_IN <= opt_t[s];
            repeat (3) @(negedge REF_CLK_IN);
            chk("ext", 32'(EXT_SEL_OUT), 32'(s == 0));
            chk("xtal", 32'(XTAL_RUN_OUT), 32'(s == 1));
            chk("rc", 32'(RC_EN_OUT), 32'(s == 2));
            chk("range", 32'(XTAL_RANGE_OUT), 32'(3 - s));
            chk("pll on", 32'(PLL_EN_OUT), 32'(s != 1));
            chk("x8", 32'(PLL_X8_OUT), 32'(opt_t[s][1] | opt_t[s][2]));
            chk("halver", 32'(HALVER_OUT), 32'(!opt_t[s][1] & opt_t[s][2]));
            @(posedge REF_CLK_IN);
            PLL_OPT_IN <= 3'h0;
            repeat (2) @(posedge REF_CLK_IN);
        end
        $display("options done");
        PLL_OPT_IN <= 3'h5;
        pll_run;
        acc(1'b0, 4'h8, 32'h7, 2'h0);
        // Halving search from the midpoint toward a target code while RC feeds the PLL
        tv = 10'h200;
        ts = 10'h100;
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 4'h0, 32'(tv[9:2]), 2'h0);
            acc(1'b1, 4'h4, 32'(tv[1:0]), 2'h0);
            @(negedge REF_CLK_IN);
            chk("search", 32'(RC_TRIM_VALUE_OUT), 32'(tv));
            tv = (tv > 10'h16A) ? tv - ts : tv + ts;
            ts = ts >> 1;
        end
        HALT_WAKEUP_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        HALT_WAKEUP_IN <= 1'b0;
        pll_run;
        $display("pll done");
        end_of_test;
    end
endmodule
`default_nettype wire
